// *** common/mhc_pkg.sv ***
// Purpose: shared constants and types for the handshake clock crossing adapter
// Assumes: one master and one slave, single-word transfers only
// Notes:   widths fixed; state codes one-hot
package mhc_pkg;
	localparam int ADDR_W    = 32;
	localparam int DATA_W    = 32;
	localparam int BE_W      = 4;
	localparam int RESP_W    = 2;
	localparam int SYNC_DEF  = 2;

	localparam logic [DATA_W-1:0] DATA_RST = 32'h0000_0000;
	localparam logic [RESP_W-1:0] RESP_RST = 2'h0;

	typedef enum logic [3:0] {
		MST_IDLE = 4'h1,
		MST_REQ  = 4'h2,
		MST_DONE = 4'h4,
		MST_DRAIN = 4'h8
	} mhc_mst_state_t;

	typedef enum logic [2:0] {
		SLV_IDLE = 3'h1,
		SLV_XFER = 3'h2,
		SLV_ACK  = 3'h4
	} mhc_slv_state_t;

	typedef struct packed {
		mhc_mst_state_t              state;
		logic                        is_write;
		logic                        req;
		logic [DATA_W-1:0]           readdata;
		logic [RESP_W-1:0]           response;
	} mhc_mst_t;

	typedef struct packed {
		mhc_slv_state_t              state;
		logic                        read;
		logic                        write;
		logic                        ack;
		logic [DATA_W-1:0]           readdata;
		logic [RESP_W-1:0]           response;
	} mhc_slv_t;
endpackage

// *** rtl/mhc_crossing.sv ***
// Purpose: handshake clock crossing between a memory-mapped master and slave
// Assumes: master holds address, data and byte enables while stalled
// Notes:   one transfer in flight; four-phase request/acknowledge levels
`timescale 1ns/100ps
//
// Contract
// - two state machines, one per clock domain, exchange read, write and wait control.
// - the request and acknowledge levels entering a state machine from the other domain pass a flip-flop synchronizer; is_write is read directly.
// - the crossing works for any ratio or phase between the two clocks.
// - a master read or write is latched and stalled by waitrequest in the same cycle.
// - only read and write control is handshaken; address, data and byte enables pass straight to the slave.
// - after capture the master side raises a request that is synchronized into the slave domain.
// - on the synchronized request the slave side runs an ordinary transfer honouring slave waitrequest.
// - when the slave transfer ends an acknowledge is returned and synchronized into the master domain.
// - the synchronized acknowledge releases master waitrequest and ends the transaction.
// - the slave sees a normal transfer and neither side needs a crossing protocol.
// - only one transaction is in flight at a time.
// - synchronizer depth is a parameter per side, two stages by default.
// - a read is lengthened by about four cycles per side plus one per direction.
// - each port's control is driven from its own domain's clock; slave address, data and byte enables come straight from the master port.
module mhc_crossing #(
	parameter int MST_SYNC = mhc_pkg::SYNC_DEF,
	parameter int SLV_SYNC = mhc_pkg::SYNC_DEF
) (
	// master domain clock and reset
	input  wire logic                       clk_i,
	input  wire logic                       reset_i,
	// master port
	input  wire logic [mhc_pkg::ADDR_W-1:0] m_address_i,
	input  wire logic                       m_read_i,
	input  wire logic                       m_write_i,
	input  wire logic [mhc_pkg::DATA_W-1:0] m_writedata_i,
	input  wire logic [mhc_pkg::BE_W-1:0]   m_byteenable_i,
	output logic                            m_waitrequest_o,
	output logic [mhc_pkg::DATA_W-1:0]      m_readdata_o,
	output logic [mhc_pkg::RESP_W-1:0]      m_response_o,
	// slave domain clock and reset
	input  wire logic                       slv_clk_i,
	input  wire logic                       slv_reset_i,
	// slave port
	output logic [mhc_pkg::ADDR_W-1:0]      s_address_o,
	output logic                            s_read_o,
	output logic                            s_write_o,
	output logic [mhc_pkg::DATA_W-1:0]      s_writedata_o,
	output logic [mhc_pkg::BE_W-1:0]        s_byteenable_o,
	input  wire logic                       s_waitrequest_i,
	input  wire logic [mhc_pkg::DATA_W-1:0] s_readdata_i,
	input  wire logic [mhc_pkg::RESP_W-1:0] s_response_i
);
	mhc_pkg::mhc_mst_t mst_reg;
	mhc_pkg::mhc_mst_t mst_next;
	mhc_pkg::mhc_slv_t slv_reg;
	mhc_pkg::mhc_slv_t slv_next;
	logic              req_in_slv;
	logic              ack_in_mst;
	logic              m_cmd;

	assign m_cmd = m_read_i | m_write_i;

	// levels only cross here, so no clock ratio is assumed
	mhc_sync #(.STAGES(SLV_SYNC)) u_req_sync (
		.clk_i   (slv_clk_i),
		.reset_i (slv_reset_i),
		.level_i (mst_reg.req),
		.level_o (req_in_slv)
	);

	mhc_sync #(.STAGES(MST_SYNC)) u_ack_sync (
		.clk_i   (clk_i),
		.reset_i (reset_i),
		.level_i (slv_reg.ack),
		.level_o (ack_in_mst)
	);

	// master domain machine
	always_comb begin
		mst_next = mst_reg;
		unique case (mst_reg.state)
			mhc_pkg::MST_IDLE: begin
				if (m_cmd) begin
					mst_next.is_write = m_write_i;
					mst_next.req      = 1'b1;
					mst_next.state    = mhc_pkg::MST_REQ;
				end
			end
			mhc_pkg::MST_REQ: begin
				if (ack_in_mst) begin
					// slave side holds its capture while ack stands, so it is quiet here
					mst_next.readdata = slv_reg.readdata;
					mst_next.response = slv_reg.response;
					mst_next.req      = 1'b0;
					mst_next.state    = mhc_pkg::MST_DONE;
				end
			end
			mhc_pkg::MST_DONE: begin
				mst_next.state = mhc_pkg::MST_DRAIN;
			end
			mhc_pkg::MST_DRAIN: begin
				// next command waits for the old ack to fall
				if (!ack_in_mst) begin
					mst_next.state = mhc_pkg::MST_IDLE;
				end
			end
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			mst_reg.state    <= mhc_pkg::MST_IDLE;
			mst_reg.is_write <= 1'b0;
			mst_reg.req      <= 1'b0;
			mst_reg.readdata <= mhc_pkg::DATA_RST;
			mst_reg.response <= mhc_pkg::RESP_RST;
		end else begin
			mst_reg <= mst_next;
		end
	end

	// stall must cover the command's first cycle, so this term cannot be registered
	assign m_waitrequest_o = m_cmd & (mst_reg.state != mhc_pkg::MST_DONE);
	assign m_readdata_o    = mst_reg.readdata;
	assign m_response_o    = mst_reg.response;

	// slave domain machine
	always_comb begin
		slv_next = slv_reg;
		unique case (slv_reg.state)
			mhc_pkg::SLV_IDLE: begin
				if (req_in_slv) begin
					slv_next.read  = ~mst_reg.is_write;
					slv_next.write = mst_reg.is_write;
					slv_next.state = mhc_pkg::SLV_XFER;
				end
			end
			mhc_pkg::SLV_XFER: begin
				if (!s_waitrequest_i) begin
					slv_next.read     = 1'b0;
					slv_next.write    = 1'b0;
					slv_next.readdata = slv_reg.read ? s_readdata_i : slv_reg.readdata;
					slv_next.response = s_response_i;
					slv_next.ack      = 1'b1;
					slv_next.state    = mhc_pkg::SLV_ACK;
				end
			end
			mhc_pkg::SLV_ACK: begin
				if (!req_in_slv) begin
					slv_next.ack   = 1'b0;
					slv_next.state = mhc_pkg::SLV_IDLE;
				end
			end
			default: begin
				slv_next.state = mhc_pkg::SLV_IDLE;
			end
		endcase
	end

	always_ff @(posedge slv_clk_i) begin
		if (slv_reset_i) begin
			slv_reg.state    <= mhc_pkg::SLV_IDLE;
			slv_reg.read     <= 1'b0;
			slv_reg.write    <= 1'b0;
			slv_reg.ack      <= 1'b0;
			slv_reg.readdata <= mhc_pkg::DATA_RST;
			slv_reg.response <= mhc_pkg::RESP_RST;
		end else begin
			slv_reg <= slv_next;
		end
	end

	// ordinary slave signalling from slave-clock flops; address and data pass through
	assign s_read_o       = slv_reg.read;
	assign s_write_o      = slv_reg.write;
	assign s_address_o    = m_address_i;
	assign s_writedata_o  = m_writedata_i;
	assign s_byteenable_o = m_byteenable_i;

	// checks, master domain
	stall_at_once_a: assert property (
		@(posedge clk_i) disable iff (reset_i)
		(mst_reg.state == mhc_pkg::MST_IDLE && m_cmd) |-> m_waitrequest_o)
		else $error("command not stalled in its first cycle");

	release_on_ack_a: assert property (
		@(posedge clk_i) disable iff (reset_i)
		(mst_reg.state == mhc_pkg::MST_REQ && ack_in_mst) |=> !m_waitrequest_o)
		else $error("master not released after acknowledge");

	req_held_a: assert property (
		@(posedge clk_i) disable iff (reset_i)
		(mst_reg.req && !ack_in_mst) |=> mst_reg.req)
		else $error("request dropped before acknowledge");

	readdata_stable_a: assert property (
		@(posedge clk_i) disable iff (reset_i)
		(mst_reg.state != mhc_pkg::MST_REQ || !ack_in_mst) |=>
			$stable({m_readdata_o, m_response_o}))
		else $error("read data moved outside a completion");

	no_reset_stall_a: assert property (
		@(posedge clk_i)
		(!reset_i && $past(reset_i)) |->
			(mst_reg.state == mhc_pkg::MST_IDLE && !mst_reg.req && m_waitrequest_o == m_cmd))
		else $error("stall without command after reset");

	// checks, slave domain
	one_inflight_a: assert property (
		@(posedge slv_clk_i) disable iff (slv_reset_i)
		!(s_read_o && s_write_o) && !(slv_reg.ack && (s_read_o || s_write_o)))
		else $error("overlapping slave transfers");

	slave_hold_a: assert property (
		@(posedge slv_clk_i) disable iff (slv_reset_i)
		((s_read_o || s_write_o) && s_waitrequest_i) |=> $stable({s_read_o, s_write_o}))
		else $error("slave command dropped under waitrequest");

	ack_after_xfer_a: assert property (
		@(posedge slv_clk_i) disable iff (slv_reset_i)
		((s_read_o || s_write_o) && !s_waitrequest_i) |=> slv_reg.ack ##1 !(s_read_o || s_write_o))
		else $error("no acknowledge after slave transfer");
endmodule

// *** rtl/mhc_sync.sv ***
// Purpose: multi-stage flip-flop synchronizer for one control level
// Assumes: input is a level held for many destination cycles
// Notes:   only the last stage is visible outside
`timescale 1ns/100ps
module mhc_sync #(
	parameter int STAGES = 2
) (
	// clock and reset
	input  wire logic clk_i,
	input  wire logic reset_i,
	// level in and out
	input  wire logic level_i,
	output logic      level_o
);
	typedef struct packed {
		logic [STAGES-1:0] chain;
	} mhc_sync_t;

	mhc_sync_t sync_reg;
	mhc_sync_t sync_next;

	always_comb begin
		sync_next = sync_reg;
		sync_next.chain = {sync_reg.chain[STAGES-2:0], level_i};
	end

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			sync_reg <= '0;
		end else begin
			sync_reg <= sync_next;
		end
	end

	assign level_o = sync_reg.chain[STAGES-1];
endmodule

// *** verif/mhc_slv_model.sv ***
// Purpose: behavioural slave on the far side of the crossing
// Assumes: four words decoded from address bits 3:2
// Notes:   wait states set by the bench; read response code taken from address bits 5:4
`timescale 1ns/100ps
module mhc_slv_model (
	// clock
	input  wire logic        clk_i,
	// slave port
	input  wire logic [31:0] addr_i,
	input  wire logic        rd_i,
	input  wire logic        wr_i,
	input  wire logic [31:0] wdata_i,
	input  wire logic [3:0]  be_i,
	input  wire logic [3:0]  waits_i,
	output logic             wait_o,
	output logic [31:0]      rdata_o,
	output logic [1:0]       resp_o
);
	logic [31:0] mem [4];
	logic [31:0] junk = 32'h0;
	logic [3:0]  cnt = 4'h0;
	assign wait_o = (rd_i | wr_i) && cnt != waits_i;
	// outside a completing read junk stays at zero, so the data lines read zero and the response lines read 3
	assign rdata_o = (rd_i && !wait_o) ? mem[addr_i[3:2]] : junk;
	assign resp_o = (rd_i && !wait_o) ? addr_i[5:4] : ~junk[1:0];
	always @(posedge clk_i) begin
		junk <= ~junk + 32'h1;
		cnt <= ((rd_i | wr_i) && wait_o) ? cnt + 4'h1 : 4'h0;
		if (wr_i && !wait_o)
			for (int i = 0; i < 4; i++)
				if (be_i[i])
					mem[addr_i[3:2]][8*i +: 8] <= wdata_i[8*i +: 8];
	end
endmodule

// *** verif/tb.sv ***
// Purpose: self-checking bench for the handshake clock crossing
// Assumes: master clock 10 ns; slave clock period set per scenario
// Notes:   master holds its command until release, then drops it
`timescale 1ns/100ps
module tb;
	logic        clk_i = 1'b0;
	logic        slv_clk_i = 1'b0;
	logic        reset_i = 1'b1;
	logic        m_rd = 1'b0;
	logic        m_wr = 1'b0;
	logic [31:0] m_addr = 32'h0;
	logic [31:0] m_wdata = 32'h0;
	logic [3:0]  m_be = 4'h0;
	logic [3:0]  waits = 4'h0;
	logic        m_wait, s_rd, s_wr, s_wait;
	logic [31:0] m_rdata, s_addr, s_wdata, s_rdata, rd;
	logic [3:0]  s_be;
	logic [1:0]  m_resp, s_resp, rsp;
	logic [2:0]  prev = 3'h0;
	real         slv_half = 8.5;
	int          error_cnt = 0;
	int          samples_checked = 0;
	int          cyc;
	mhc_crossing DUT (.clk_i(clk_i), .reset_i(reset_i), .slv_clk_i(slv_clk_i),
		.slv_reset_i(reset_i), .m_address_i(m_addr), .m_read_i(m_rd), .m_write_i(m_wr),
		.m_writedata_i(m_wdata), .m_byteenable_i(m_be), .m_waitrequest_o(m_wait),
		.m_readdata_o(m_rdata), .m_response_o(m_resp), .s_address_o(s_addr),
		.s_read_o(s_rd), .s_write_o(s_wr), .s_writedata_o(s_wdata), .s_byteenable_o(s_be),
		.s_waitrequest_i(s_wait), .s_readdata_i(s_rdata), .s_response_i(s_resp));
	mhc_slv_model SLV (.clk_i(slv_clk_i), .addr_i(s_addr), .rd_i(s_rd), .wr_i(s_wr),
		.wdata_i(s_wdata), .be_i(s_be), .waits_i(waits), .wait_o(s_wait),
		.rdata_o(s_rdata), .resp_o(s_resp));
	initial forever #5 clk_i = ~clk_i;
	initial forever #(slv_half) slv_clk_i = ~slv_clk_i;
	task automatic check(input logic [63:0] got, input logic [63:0] exp);
		samples_checked++;
		if (got !== exp) begin
			error_cnt++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic results();
		$display("checks %0d errors %0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	// a stalled slave transfer must keep its strobes until the slave lets go
	always @(negedge slv_clk_i) begin
		check(s_rd & s_wr, 1'b0);
		if (!reset_i && ((prev[2] | prev[1]) & prev[0]))
			check({s_rd, s_wr}, prev[2:1]);
		prev <= {s_rd, s_wr, s_wait};
	end
	// waitrequest is combinational, so it is looked at mid-cycle
	task automatic xfer(input logic wr, input logic [31:0] a, d, input logic [3:0] be);
		@(negedge clk_i);
		m_rd = !wr;
		m_wr = wr;
		m_addr = a;
		m_wdata = d;
		m_be = be;
		#1 check(m_wait, 1'b1);
		check({s_be, s_addr}, {be, a});
		check(s_wdata, d);
		for (cyc = 1; m_wait !== 1'b0; cyc++) begin
			@(negedge clk_i);
			if (cyc == 300) begin
				error_cnt++;
				results();
			end
		end
		rd = m_rdata;
		rsp = m_resp;
		@(negedge clk_i);
		m_rd = 1'b0;
		m_wr = 1'b0;
		m_addr = ~a;
		m_wdata = ~d;
	endtask
	task automatic t_write_read();
		xfer(1'b1, 32'h0000_0004, 32'hA5A5_5A5A, 4'hF);
		check(cyc <= 24, 1'b1);
		xfer(1'b0, 32'h0000_0004, 32'h0, 4'hF);
		check({rsp, rd}, {2'h0, 32'hA5A5_5A5A});
	endtask
	task automatic t_slow_slave();
		waits = 4'h5;
		xfer(1'b1, 32'h0000_0008, 32'hFFFF_FFFF, 4'hF);
		xfer(1'b1, 32'h0000_0008, 32'h1122_3344, 4'h5);
		xfer(1'b0, 32'h0000_0028, 32'h0, 4'hF);
		check({rsp, rd}, {2'h2, 32'hFF22_FF44});
		xfer(1'b0, 32'h0000_0034, 32'h0, 4'hF);
		check({rsp, rd}, {2'h3, 32'hA5A5_5A5A});
	endtask
	task automatic t_ratios();
		real halves[2] = '{1.5, 23.0};
		foreach (halves[i]) begin
			slv_half = halves[i];
			waits = 4'h1;
			xfer(1'b1, 32'h0000_000C, {28'hDEAD_BEE, i[3:0]}, 4'hF);
			xfer(1'b0, 32'h0000_001C, 32'h0, 4'hF);
			check({rsp, rd}, {2'h1, 28'hDEAD_BEE, i[3:0]});
		end
	endtask
	// reset cuts a stalled command; long hold covers the slow slave clock
	task automatic t_reset();
		@(negedge clk_i);
		m_rd = 1'b1;
		m_addr = 32'h0000_0000;
		repeat (3) @(negedge clk_i);
		check(m_wait, 1'b1);
		reset_i = 1'b1;
		m_rd = 1'b0;
		repeat (20) @(negedge clk_i);
		reset_i = 1'b0;
		check({m_wait, s_rd, s_wr, m_resp, m_rdata}, 37'h0);
		xfer(1'b0, 32'h0000_0004, 32'h0, 4'hF);
		check({rsp, rd}, {2'h0, 32'hA5A5_5A5A});
	endtask
	initial begin
		repeat (10) @(negedge clk_i);
		reset_i = 1'b0;
		check({m_wait, s_rd, s_wr, m_resp, m_rdata}, 37'h0);
		t_write_read();
		t_slow_slave();
		t_ratios();
		t_reset();
		results();
	end
endmodule
